// ===== rtl/ipsw_top.sv
// Interrupt priority arbitration, nesting and standby wake control
// Functional notes
// - Three levels; level ranks every request first
// - Refuse requests at or below service level
// - Simultaneous requests: highest level wins
// - Same level: lowest vector address wins
// - 41 sources merge onto 10 vectors
// - Halt stops the core, peripherals run
// - Halt leaves oscillators as configured
// - Halt ends on reset, watchdog, interrupt
// - Full hold stops everything, all oscillators
// - Full hold ends on listed wake sources
// - Crystal hold keeps only base timer running
// - Crystal hold stops PLL, ceramic, RC
// - Crystal state frozen as at entry
// - Crystal hold adds base timer, remote wakes
module ipsw_top
	import ipsw_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// Request sources from peripherals and pins, asynchronous levels
	input  wire logic [NUM_SRC-1:0] irq_src,
	input  wire logic [NUM_SRC-1:0] src_enable,
	// Per-vector level choice, set selects the upper level
	input  wire logic [NUM_VEC-1:0] vec_upper,
	// Reset sources
	input  wire logic               res_pin_n,
	input  wire logic               wdt_reset,
	// Core side
	input  wire logic               irq_ack,
	input  wire logic               irq_return,
	input  wire logic               halt_req,
	input  wire logic               hold_req,
	input  wire logic               xhold_req,
	output logic                    irq_req_ff,
	output logic [3:0]              irq_vec_ff,
	output logic [ADDR_W-1:0]       irq_vec_addr_ff,
	output ipsw_lvl_t               irq_lvl_ff,
	output ipsw_lvl_t               svc_lvl_ff,
	// Clock and run control
	input  wire ipsw_osc_s          osc_cfg,
	output ipsw_osc_s               osc_en_ff,
	output logic                    cpu_run_ff,
	output logic                    periph_run_ff,
	output logic                    base_timer_run_ff,
	output ipsw_mode_e              mode_ff
);

	// Synchronised inputs and internal decode
	logic [NUM_SRC-1:0]      src_sync;     // Sources after two flops
	logic                    res_sync_n;   // Reset pin after two flops
	logic [NUM_SRC-1:0]      src_act;      // Enabled and asserted sources
	logic [NUM_VEC-1:0]      vec_pend;     // Vector has a live source
	ipsw_lvl_t [NUM_VEC-1:0] vec_lvl;      // Level of each vector
	ipsw_lvl_t               cur_lvl;      // Level now in service
	ipsw_grant_s             grant;        // Arbiter winner
	logic                    reset_evt;    // Pin or watchdog reset
	logic                    pend_any;     // Any interrupt generated
	logic                    hold_wake;    // Full hold wake event
	logic                    xhold_wake;   // Crystal hold wake event
	logic                    acc;          // Request taken by the core

	// Nesting state
	logic [2:0]  isr_ff;                   // One bit per level in service
	logic [2:0]  nxt_isr;
	logic        nxt_irq_req;
	logic [3:0]  nxt_irq_vec;
	ipsw_lvl_t   nxt_irq_lvl;

	// Standby state
	ipsw_mode_e  nxt_mode;
	ipsw_osc_s   nxt_osc_en;

	// Pins and peripheral flags may come from other clocks, so all pass two flops
	ipsw_sync #(
		.W (NUM_SRC + 1)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({res_pin_n, irq_src}),
		.sync_out ({res_sync_n, src_sync})
	);

	// Source merge and per-vector level
	always_comb begin
		src_act  = src_sync & src_enable;
		vec_pend = '0;
		vec_lvl  = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (src_act[s]) begin
				vec_pend[SRC_VEC[s]] = 1'b1;
			end
		end
		for (int v = 0; v < NUM_VEC; v++) begin
			if (!vec_upper[v]) begin
				vec_lvl[v] = LVL_LOW;
			end else if (v < TOP_LVL_VECS) begin
				vec_lvl[v] = LVL_HIGHEST;
			end else begin
				vec_lvl[v] = LVL_HIGH;
			end
		end
	end

	// Current service level is the top in-service bit
	always_comb begin
		if (isr_ff[2]) begin
			cur_lvl = LVL_HIGHEST;
		end else if (isr_ff[1]) begin
			cur_lvl = LVL_HIGH;
		end else if (isr_ff[0]) begin
			cur_lvl = LVL_LOW;
		end else begin
			cur_lvl = LVL_NONE;
		end
	end

	ipsw_arb u_arb (
		.vec_pend (vec_pend),
		.vec_lvl  (vec_lvl),
		.cur_lvl  (cur_lvl),
		.grant    (grant)
	);

	// Wake events; pins a and b hold their level only if software set level detect
	always_comb begin
		reset_evt  = !res_sync_n || wdt_reset;
		pend_any   = |src_act;
		hold_wake  = |(src_act & HOLD_WAKE_MASK);
		xhold_wake = |(src_act & XHOLD_WAKE_MASK);
		acc        = irq_ack && irq_req_ff;
	end

	// Nesting and request next state
	always_comb begin
		nxt_isr     = isr_ff;
		nxt_irq_vec = irq_vec_ff;
		nxt_irq_lvl = irq_lvl_ff;
		if (irq_return) begin
			if (isr_ff[2]) begin
				nxt_isr[2] = 1'b0;
			end else if (isr_ff[1]) begin
				nxt_isr[1] = 1'b0;
			end else begin
				nxt_isr[0] = 1'b0;
			end
		end
		if (acc && (irq_lvl_ff != LVL_NONE)) begin
			nxt_isr[irq_lvl_ff - 2'h1] = 1'b1;
		end
		// A pin or watchdog reset abandons all nesting
		if (reset_evt) begin
			nxt_isr = '0;
		end
		// Request only while running; dropped when taken or as standby begins
		nxt_irq_req = grant.valid && !acc && !reset_evt && (nxt_mode == MODE_RUN);
		if (grant.valid && !acc) begin
			nxt_irq_vec = grant.vec;
			nxt_irq_lvl = grant.lvl;
		end
	end

	// Nesting registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			isr_ff          <= '0;
			irq_req_ff      <= 1'b0;
			irq_vec_ff      <= '0;
			irq_vec_addr_ff <= '0;
			irq_lvl_ff      <= LVL_NONE;
			svc_lvl_ff      <= LVL_NONE;
		end else begin
			isr_ff          <= nxt_isr;
			irq_req_ff      <= nxt_irq_req;
			irq_vec_ff      <= nxt_irq_vec;
			irq_vec_addr_ff <= VEC_ADDR[nxt_irq_vec];
			irq_lvl_ff      <= nxt_irq_lvl;
			svc_lvl_ff      <= cur_lvl;
		end
	end

	// Standby next state and run/oscillator controls
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			MODE_RUN: begin
				// Deeper request wins if several arrive at once
				if (reset_evt) begin
					nxt_mode = MODE_RUN;
				end else if (hold_req) begin
					nxt_mode = MODE_HOLD;
				end else if (xhold_req) begin
					nxt_mode = MODE_XHOLD;
				end else if (halt_req) begin
					nxt_mode = MODE_HALT;
				end
			end
			MODE_HALT: begin
				if (reset_evt || pend_any) begin
					nxt_mode = MODE_RUN;
				end
			end
			MODE_HOLD: begin
				if (reset_evt || hold_wake) begin
					nxt_mode = MODE_RUN;
				end
			end
			MODE_XHOLD: begin
				if (reset_evt || xhold_wake) begin
					nxt_mode = MODE_RUN;
				end
			end
			default: begin
				nxt_mode = MODE_RUN;
			end
		endcase
		nxt_osc_en = osc_cfg;
		if (nxt_mode == MODE_HOLD) begin
			nxt_osc_en = '0;
		end else if (nxt_mode == MODE_XHOLD) begin
			nxt_osc_en = '0;
			nxt_osc_en.xtal = (mode_ff == MODE_XHOLD) ? osc_en_ff.xtal : osc_cfg.xtal;
		end
	end

	// Standby registers; outputs follow the next mode so they match mode_ff
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff           <= MODE_RUN;
			osc_en_ff         <= '0;
			cpu_run_ff        <= 1'b1;
			periph_run_ff     <= 1'b1;
			base_timer_run_ff <= 1'b1;
		end else begin
			mode_ff           <= nxt_mode;
			osc_en_ff         <= nxt_osc_en;
			cpu_run_ff        <= (nxt_mode == MODE_RUN);
			periph_run_ff     <= (nxt_mode == MODE_RUN) || (nxt_mode == MODE_HALT);
			base_timer_run_ff <= (nxt_mode != MODE_HOLD);
		end
	end

	// Checks
	// request above service level
	chk_req_above_svc: assert property (@(posedge clock) disable iff (!rst_n)
		irq_req_ff && !$past(acc) && !$past(irq_return) |-> irq_lvl_ff > svc_lvl_ff)
		else $error("request not above service level");
	chk_vec_addr_map: assert property (@(posedge clock) disable iff (!rst_n)
		irq_req_ff |-> irq_vec_addr_ff == VEC_ADDR[irq_vec_ff])
		else $error("vector address mismatch");
	chk_accept_raise: assert property (@(posedge clock) disable iff (!rst_n)
		acc && !irq_return && !reset_evt |=> cur_lvl == $past(irq_lvl_ff))
		else $error("service level not raised");
	chk_return_lower: assert property (@(posedge clock) disable iff (!rst_n)
		irq_return && !acc && (isr_ff != 3'h0) |=> cur_lvl < $past(cur_lvl))
		else $error("service level not restored");
	chk_halt_core_off: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_HALT |-> !cpu_run_ff && periph_run_ff && !irq_req_ff)
		else $error("halt run controls wrong");
	chk_halt_osc_cfg: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_HALT |-> osc_en_ff == $past(osc_cfg))
		else $error("halt changed oscillators");
	chk_hold_all_off: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_HOLD |-> osc_en_ff == 4'h0 && !periph_run_ff && !base_timer_run_ff)
		else $error("full hold left something running");
	chk_xhold_osc_off: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_XHOLD |-> !osc_en_ff.pll && !osc_en_ff.cf && !osc_en_ff.rc
			&& base_timer_run_ff && !periph_run_ff)
		else $error("crystal hold controls wrong");
	chk_xhold_xtal_keep: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_XHOLD && $past(mode_ff) == MODE_XHOLD |-> $stable(osc_en_ff.xtal))
		else $error("crystal state changed in hold");
	chk_halt_wake_run: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_HALT && (reset_evt || pend_any) |=> mode_ff == MODE_RUN && cpu_run_ff)
		else $error("halt did not release");
	chk_hold_stay: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_HOLD && !reset_evt && !hold_wake |=> mode_ff == MODE_HOLD)
		else $error("full hold left without wake source");
	chk_xhold_wake_run: assert property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_XHOLD && (reset_evt || xhold_wake) |=> mode_ff == MODE_RUN)
		else $error("crystal hold did not release");

	// Main scenarios: nesting and the two hold wakes
	cov_nested_accept: cover property (@(posedge clock) disable iff (!rst_n)
		acc && cur_lvl != LVL_NONE);
	cov_hold_wake: cover property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_HOLD ##1 mode_ff == MODE_RUN);
	cov_xhold_wake: cover property (@(posedge clock) disable iff (!rst_n)
		mode_ff == MODE_XHOLD ##1 mode_ff == MODE_RUN);

endmodule : ipsw_top

// ===== rtl/ipsw_pkg.sv
// Package: shared constants, types and maps for the interrupt priority and standby wake block
package ipsw_pkg;

	// Source and vector counts
	localparam int NUM_SRC  = 41;
	localparam int NUM_VEC  = 10;
	localparam int ADDR_W   = 17;

	// Priority level codes, larger is more urgent; zero means nothing in service
	typedef logic [1:0] ipsw_lvl_t;
	localparam ipsw_lvl_t LVL_NONE    = 2'h0;
	localparam ipsw_lvl_t LVL_LOW     = 2'h1;
	localparam ipsw_lvl_t LVL_HIGH    = 2'h2;
	localparam ipsw_lvl_t LVL_HIGHEST = 2'h3;

	// Vectors below this index take the highest level as their upper choice
	localparam int TOP_LVL_VECS = 2;

	// Vector entry addresses, index 0 is the smallest address
	localparam logic [NUM_VEC-1:0][ADDR_W-1:0] VEC_ADDR = {
		17'h0004B, 17'h00043, 17'h0003B, 17'h00033, 17'h0002B,
		17'h00023, 17'h0001B, 17'h00013, 17'h0000B, 17'h00003};

	// Vector index of every source, source 40 first
	localparam logic [NUM_SRC-1:0][3:0] SRC_VEC = {
		4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9,
		4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8,
		4'h7, 4'h7, 4'h7, 4'h7,
		4'h6, 4'h6,
		4'h5, 4'h5, 4'h5, 4'h5, 4'h5,
		4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
		4'h3, 4'h3, 4'h3,
		4'h2, 4'h2, 4'h2, 4'h2, 4'h2,
		4'h1,
		4'h0};

	// Sources that end full hold: pins a, b, c, group lo, group hi, port bank 0, bus active
	localparam logic [NUM_SRC-1:0] HOLD_WAKE_MASK  = 41'h200000137;
	// Crystal hold adds the base timer and the remote receiver
	localparam logic [NUM_SRC-1:0] XHOLD_WAKE_MASK = 41'h200000377;

	// Standby modes, one-hot
	typedef enum logic [3:0] {
		MODE_RUN   = 4'h1,
		MODE_HALT  = 4'h2,
		MODE_HOLD  = 4'h4,
		MODE_XHOLD = 4'h8
	} ipsw_mode_e;

	// Oscillator and reference enables
	typedef struct packed {
		logic pll;
		logic cf;
		logic rc;
		logic xtal;
	} ipsw_osc_s;

	// Arbiter result
	typedef struct packed {
		logic      valid;
		logic [3:0] vec;
		ipsw_lvl_t lvl;
	} ipsw_grant_s;

endpackage : ipsw_pkg

// ===== rtl/ipsw_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
module ipsw_sync
	import ipsw_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage_ff;  // First stage, read only by the second

	// Two stages; the first is never looked at by any other logic
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_ff <= '0;
			sync_out <= '0;
		end else begin
			stage_ff <= async_in;
			sync_out <= stage_ff;
		end
	end

endmodule : ipsw_sync

// ===== rtl/ipsw_arb.sv
// Combinational arbiter: best pending vector above the in-service level
module ipsw_arb
	import ipsw_pkg::*;
(
	// Pending vectors and their levels
	input  wire logic      [NUM_VEC-1:0] vec_pend,
	input  wire ipsw_lvl_t [NUM_VEC-1:0] vec_lvl,
	// Level now in service
	input  wire ipsw_lvl_t               cur_lvl,
	// Winner
	output ipsw_grant_s                  grant
);

	// Scan from the largest address down so a tie leaves the smallest one
	always_comb begin
		grant = '0;
		for (int v = NUM_VEC - 1; v >= 0; v--) begin
			if (vec_pend[v] && (vec_lvl[v] > cur_lvl)) begin
				if (!grant.valid || (vec_lvl[v] >= grant.lvl)) begin
					grant.valid = 1'b1;
					grant.vec   = 4'(v);
					grant.lvl   = vec_lvl[v];
				end
			end
		end
	end

endmodule : ipsw_arb

// ===== tb/ipsw_core_model.sv
// CPU core stand-in that takes interrupt requests after a chosen delay
module ipsw_core_model
	import ipsw_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Request side of the controller
	input  wire logic       irq_req_ff,
	input  wire logic [3:0] irq_vec_ff,
	// Bench control: enable and delay in cycles
	input  wire logic       ack_en,
	input  wire logic [1:0] slow,
	// Answer to the controller
	output logic            irq_ack,
	output logic [3:0]      taken_vec
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_cnt; // Cycles spent on the standing request
	// Ack only while a request stands; one pulse per request
	always @(negedge clock) begin
		if (!rst_n) begin
			irq_ack   <= 1'b0;
			taken_vec <= 4'h0;
			wait_cnt  <= 2'h0;
		end else if (!ack_en || !irq_req_ff || irq_ack) begin
			irq_ack  <= 1'b0;
			wait_cnt <= 2'h0;
		end else if (wait_cnt >= slow) begin
			irq_ack   <= 1'b1;
			taken_vec <= irq_vec_ff;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule : ipsw_core_model

// ===== tb/tb_top.sv
// Self-checking bench for the interrupt priority and standby wake block
module tb_top
	import ipsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// One arbitration case: sources, level choices, expected winner
	typedef struct packed {
		logic [40:0] src;
		logic [9:0]  up;
		logic [3:0]  vec;
		ipsw_lvl_t   lvl;
	} ipsw_row_s;
	logic clock, rst_n, res_pin_n, wdt_reset, irq_ack, irq_return;
	logic halt_req, hold_req, xhold_req, ack_en;
	logic irq_req_ff, cpu_run_ff, periph_run_ff, base_timer_run_ff;
	logic [40:0] irq_src, src_enable;
	logic [9:0]  vec_upper;
	logic [3:0]  irq_vec_ff, taken_vec;
	logic [16:0] irq_vec_addr_ff;
	logic [1:0]  slow;
	ipsw_lvl_t   irq_lvl_ff, svc_lvl_ff;
	ipsw_osc_s   osc_cfg, osc_en_ff;
	ipsw_mode_e  mode_ff;
	int n_errors = 0;
	int checks = 0;
	// Single sources, ties and pairs of sources, each source on its own vector
	ipsw_row_s rows [7] = '{
		'{41'h1, 10'h0, 4'h0, LVL_LOW},
		'{41'h3, 10'h2, 4'h1, LVL_HIGHEST},
		'{41'h3, 10'h3, 4'h0, LVL_HIGHEST},
		'{41'h10000000008, 10'h0, 4'h2, LVL_LOW},
		'{41'h10000000008, 10'h200, 4'h9, LVL_HIGH},
		'{41'h4100000, 10'h140, 4'h6, LVL_HIGH},
		'{41'h400000000, 10'h0, 4'h9, LVL_LOW}};

	ipsw_top ipsw_top_i(.clock, .rst_n, .irq_src, .src_enable, .vec_upper, .res_pin_n,
		.wdt_reset, .irq_ack, .irq_return, .halt_req, .hold_req, .xhold_req, .irq_req_ff,
		.irq_vec_ff, .irq_vec_addr_ff, .irq_lvl_ff, .svc_lvl_ff, .osc_cfg, .osc_en_ff,
		.cpu_run_ff, .periph_run_ff, .base_timer_run_ff, .mode_ff);
	ipsw_core_model ipsw_core_model_i(.clock, .rst_n, .irq_req_ff, .irq_vec_ff,
		.ack_en, .slow, .irq_ack, .taken_vec);

	// Free-running system clock
	always #20 clock = ~clock;

	// Single end of run for both the tests and the watchdog
	task print_verdict();
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	// Four-state compare; an unknown matches only the same unknown
	task chk(input logic [16:0] got, input logic [16:0] exp);
		checks++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	// Return from service and expect the level below
	task ret(input ipsw_lvl_t exp);
		irq_return = 1'b1;
		@(negedge clock);
		irq_return = 1'b0;
		repeat (2) @(negedge clock);
		chk(svc_lvl_ff, exp);
	endtask : ret

	// Enter a standby mode, try a non-waking source, then wake it
	task sb(input logic [2:0] kind, input ipsw_mode_e m, input int bad, input int good);
		logic [3:0] exp_osc;
		exp_osc = (m == MODE_HALT) ? osc_cfg : (m == MODE_HOLD) ? 4'h0 : {3'h0, osc_cfg.xtal};
		{hold_req, xhold_req, halt_req} = kind;
		@(negedge clock);
		{hold_req, xhold_req, halt_req} = 3'h0;
		chk(mode_ff, m);
		chk(cpu_run_ff, 1'b0);
		chk(periph_run_ff, m == MODE_HALT);
		chk(base_timer_run_ff, m != MODE_HOLD);
		chk(osc_en_ff, exp_osc);
		// Crystal state must not follow software while held
		if (m != MODE_HALT) begin
			osc_cfg = ~osc_cfg;
			@(negedge clock);
			chk(osc_en_ff, exp_osc);
			osc_cfg = ~osc_cfg;
		end
		if (bad >= 0) begin
			irq_src[bad] = 1'b1;
			repeat (4) @(negedge clock);
			chk(mode_ff, m);
			irq_src = '0;
		end
		// pin wake sources are held as levels
		if (good == -1) wdt_reset = 1'b1;
		else if (good == -2) res_pin_n = 1'b0;
		else irq_src[good] = 1'b1;
		repeat (2) @(negedge clock);
		wdt_reset = 1'b0;
		res_pin_n = 1'b1;
		repeat (2) @(negedge clock);
		chk(mode_ff, MODE_RUN);
		irq_src = '0;
		repeat (6) @(negedge clock);
	endtask : sb

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(negedge clock);
		n_errors++;
		print_verdict();
	end

	// Main sequence, inputs change on the falling edge
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		{irq_src, vec_upper, wdt_reset, irq_return, ack_en, slow} = '0;
		{halt_req, hold_req, xhold_req} = 3'h0;
		src_enable = '1;
		res_pin_n = 1'b1;
		osc_cfg = 4'hB;
		repeat (20) @(negedge clock);
		chk(osc_en_ff, 4'h0);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		chk(mode_ff, MODE_RUN);
		chk(osc_en_ff, osc_cfg);
		// Arbitration table, core not taking anything
		foreach (rows[i]) begin
			vec_upper = rows[i].up;
			irq_src = rows[i].src;
			repeat (4) @(negedge clock);
			chk(irq_req_ff, 1'b1);
			chk(irq_vec_ff, rows[i].vec);
			chk(irq_vec_addr_ff, VEC_ADDR[rows[i].vec]);
			chk(irq_lvl_ff, rows[i].lvl);
			irq_src = '0;
			repeat (4) @(negedge clock);
		end
		// A disabled source raises no request
		src_enable[0] = 1'b0;
		irq_src[0] = 1'b1;
		repeat (4) @(negedge clock);
		chk(irq_req_ff, 1'b0);
		irq_src = '0;
		repeat (3) @(negedge clock);
		src_enable = '1;
		@(negedge clock);
		// Nesting with a slow core: equal level refused, higher nests
		vec_upper = '0;
		ack_en = 1'b1;
		slow = 2'h2;
		irq_src[3] = 1'b1;
		repeat (8) @(negedge clock);
		chk(taken_vec, 4'h2);
		chk(svc_lvl_ff, LVL_LOW);
		irq_src[10] = 1'b1;
		repeat (6) @(negedge clock);
		chk(irq_req_ff, 1'b0);
		vec_upper[4] = 1'b1;
		repeat (8) @(negedge clock);
		chk(taken_vec, 4'h4);
		chk(svc_lvl_ff, LVL_HIGH);
		ack_en = 1'b0;
		irq_src = '0;
		vec_upper = '0;
		ret(LVL_LOW);
		ret(LVL_NONE);
		// Standby entries and their wake sources
		sb(3'h1, MODE_HALT, -1, 7);
		sb(3'h4, MODE_HOLD, 7, 33);
		sb(3'h2, MODE_XHOLD, 10, 9);
		sb(3'h4, MODE_HOLD, 6, 5);
		sb(3'h2, MODE_XHOLD, 3, 1);
		sb(3'h2, MODE_XHOLD, -1, 6);
		sb(3'h1, MODE_HALT, -1, -1);
		sb(3'h4, MODE_HOLD, 9, -2);
		print_verdict();
	end
endmodule : tb_top
